// ==== sim/testbench.sv ====
`timescale 1ns/1ns
`include "ref_ladder_params.svh"
module testbench;
   import ref_ladder_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic ref_clk, reset_n, read, write, waitrequest;
   logic [3:0] address, byteenable, ref_level_code;
   logic [31:0] writedata, readdata, rd;
   logic ladder_enable, ref_pin_output_enable, ref_source_select;
   range_t ref_range_select;
   int mismatches = 0; // Failed compares
   int n_checks = 0; // Compares made through check; bus timeouts are not counted
   // Control outputs laid out as the register image
   wire [31:0] outs = {16'h0000, ladder_enable, 8'h00, ref_pin_output_enable,
      ref_range_select, ref_source_select, ref_level_code};
   // Ordinary cases: lanes, write data, expected image
   typedef struct packed {logic [3:0] be; logic [31:0] wd; logic [31:0] ex;} row_t;
   row_t rows [8] = '{
      '{4'hf, 32'hffff_ffff, 32'h0000_807f}, '{4'h2, 32'h0000_0000, 32'h0000_007f},
      '{4'h1, 32'h0000_0025, 32'h0000_0025}, '{4'h2, 32'hffff_8000, 32'h0000_8025},
      '{4'h1, 32'h0000_005a, 32'h0000_805a}, '{4'h3, 32'h0000_0010, 32'h0000_0010},
      '{4'hc, 32'hffff_ffff, 32'h0000_0010}, '{4'h3, 32'h0000_806f, 32'h0000_806f}};

   reference_ladder_control uut (.ref_clk(ref_clk), .reset_n(reset_n), .address(address),
      .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .ladder_enable(ladder_enable),
      .ref_pin_output_enable(ref_pin_output_enable), .ref_range_select(ref_range_select),
      .ref_source_select(ref_source_select), .ref_level_code(ref_level_code));

   // ----------------------------------------
   // Clock, compare, bus master, closing
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   // One Avalon access; starts a fresh edge so no signal is driven twice per step
   task automatic bus(input logic wr, input logic [3:0] a, input logic [3:0] be,
         input logic [31:0] d);
      int t;
      t = 0;
      @(posedge ref_clk);
      address <= a;
      byteenable <= be;
      writedata <= d;
      write <= wr;
      read <= !wr;
      // Request stands until waitrequest is sampled low at a rising edge
      do begin
         @(posedge ref_clk);
         t++;
      end while (waitrequest !== 1'b0 && t < 20);
      if (t >= 20) begin
         mismatches++;
         $display("[ERR] t=%0t no answer seen=%h expected=%h", $time, waitrequest, 1'b0);
      end
      // Read data taken at the answering edge, then the request is dropped
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog, far beyond the 75 or so cycles the tests need
   initial begin
      #200000;
      mismatches++;
      test_done();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      reset_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 4'h0;
      byteenable = 4'h0;
      writedata = 32'h0000_0000;
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(negedge ref_clk);
      check(outs, 32'h0000_0000);
      bus(1'b0, `REF_CTRL_ADDR, 4'hf, 32'h0000_0000);
      check(rd, `REF_CTRL_RESET);
      $display("reset test done");
      // Rows: write, outputs follow, readback agrees
      foreach (rows[i]) begin
         bus(1'b1, `REF_CTRL_ADDR, rows[i].be, rows[i].wd);
         // Outputs settle; the next access waits a full idle cycle
         @(negedge ref_clk);
         check(outs, rows[i].ex);
         bus(1'b0, `REF_CTRL_ADDR, 4'hf, 32'h0000_0000);
         check(rd, rows[i].ex);
      end
      $display("row test done");
      // Unmapped place: write lost, read gives zero
      bus(1'b1, 4'h1, 4'hf, 32'h0000_0000);
      @(negedge ref_clk);
      check(outs, 32'h0000_806f);
      bus(1'b0, 4'h1, 4'hf, 32'h0000_0000);
      check(rd, `REF_UNMAPPED_DATA);
      $display("unmapped test done");
      // Reset in mid-run clears the stored fields
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(negedge ref_clk);
      check(outs, 32'h0000_0000);
      bus(1'b0, `REF_CTRL_ADDR, 4'hf, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      $display("second reset test done");
      test_done();
   end
endmodule // testbench

// ==== src/ref_ctrl_field.sv ====
`timescale 1ns/1ns
// Generic field register: loads din whole when load is high, holds otherwise
module ref_ctrl_field #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Load control
   input wire logic load,
   input wire logic [W-1:0] din,
   // Stored value
   output logic [W-1:0] q
);
   logic [W-1:0] q_nxt;

   // Next value: load wins, else hold
   always_comb begin
      q_nxt = load ? din : q;
   end

   // Register only
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= q_nxt;
      end
   end
endmodule // ref_ctrl_field

// ==== src/ref_ladder_params.svh ====
`ifndef REF_LADDER_PARAMS_SVH
`define REF_LADDER_PARAMS_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define REF_CTRL_ADDR 4'h0
`define REF_CTRL_RESET 32'h0000_0000

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define REF_ON_BIT 15
`define REF_OE_BIT 6
`define REF_RANGE_BIT 5
`define REF_SRC_BIT 4
`define REF_LEVEL_MSB 3
`define REF_LEVEL_LSB 0
`define REF_IMPL_MASK 32'h0000_807f

// ------------------------------------------------------------
// Ladder constants
// ------------------------------------------------------------
`define REF_LOW_RANGE_DIV 24
`define REF_HIGH_RANGE_DIV 32
`define REF_UNMAPPED_DATA 32'h0000_0000

`endif

// ==== src/ref_ladder_pkg.sv ====
package ref_ladder_pkg;
   // Bus access kind seen by the slave
   typedef enum logic [1:0] {ACC_IDLE, ACC_READ, ACC_WRITE} acc_kind_t;
   // Ladder range choice
   typedef enum logic {RANGE_QUARTER = 1'b0, RANGE_LOW = 1'b1} range_t;
endpackage

// ==== src/reference_ladder_control.sv ====
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "ref_ladder_params.svh"

// Operation
// - Enable bit clear disables generator, set enables
// - Setting enable leaves other fields unchanged
// - Clearing enable leaves other fields unchanged
// - Bit 6 connects level to pin
// - Range bit one: zero base, span/24 steps
// - Range bit zero: quarter base, span/32 steps
// - Source bit zero selects supply rails
// - Source bit one selects external reference pins
// - Unimplemented bits ignore writes, read zero
module reference_ladder_control (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Analog ladder controls
   output logic ladder_enable,
   output logic ref_pin_output_enable,
   output ref_ladder_pkg::range_t ref_range_select,
   output logic ref_source_select,
   output logic [3:0] ref_level_code
);
   import ref_ladder_pkg::*;

   // ------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------
   // Accept state: waitrequest drops one cycle after a request
   // A fixed single wait cycle keeps the read path registered, at the
   // cost of two clocks per access; this register is rarely touched
   logic ack_r; // Request seen last cycle, answer this cycle
   logic ack_nxt; // Next accept state
   logic [31:0] readdata_nxt; // Next read data, held between reads
   logic hit; // Address matches the control register
   logic wr_lo; // Write strobe, low byte lane
   logic wr_hi; // Write strobe, second byte lane
   logic [31:0] ctrl_view; // Register as read by software

   assign hit = (address == `REF_CTRL_ADDR);
   assign wr_lo = write && ack_r && hit && byteenable[0];
   assign wr_hi = write && ack_r && hit && byteenable[1];

   // Each request waits exactly one cycle, then completes
   always_comb begin
      ack_nxt = (read || write) && !ack_r;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
         waitrequest <= 1'b1;
      end else begin
         ack_r <= ack_nxt;
         waitrequest <= !ack_nxt;
      end
   end

   // ------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------
   // The enable bit and the low byte load independently, so the enable bit never disturbs
   // the others and vice versa
   ref_ctrl_field #(.W(1)) u_on (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .load(wr_hi),
      .din(writedata[`REF_ON_BIT]),
      .q(ladder_enable)
   );

   logic [6:0] low_q; // OE, range, source, level
   ref_ctrl_field #(.W(7)) u_low (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .load(wr_lo),
      .din(writedata[6:0]),
      .q(low_q)
   );

   // Outputs come straight from the field flops
   assign ref_pin_output_enable = low_q[`REF_OE_BIT];
   assign ref_range_select = range_t'(low_q[`REF_RANGE_BIT]);
   assign ref_source_select = low_q[`REF_SRC_BIT];
   assign ref_level_code = low_q[`REF_LEVEL_MSB:`REF_LEVEL_LSB];

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // Unimplemented bits are simply absent, so they read zero
   always_comb begin
      ctrl_view = `REF_CTRL_RESET;
      ctrl_view[`REF_ON_BIT] = ladder_enable;
      ctrl_view[6:0] = low_q;
      readdata_nxt = readdata;
      if (read && ack_nxt) begin
         readdata_nxt = hit ? (ctrl_view & `REF_IMPL_MASK) : `REF_UNMAPPED_DATA;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         readdata <= 32'h0000_0000;
      end else begin
         readdata <= readdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_on_follows_write;
      @(posedge ref_clk) disable iff (!reset_n)
      wr_hi |=> ladder_enable == $past(writedata[`REF_ON_BIT]);
   endproperty
   a_on_follows_write: assert property (p_on_follows_write)
      else $error("enable bit did not follow write");

   property p_low_hold_on_hi_only;
      @(posedge ref_clk) disable iff (!reset_n)
      (wr_hi && !wr_lo) |=> $stable(low_q);
   endproperty
   a_low_hold_on_hi_only: assert property (p_low_hold_on_hi_only)
      else $error("other fields changed on enable-only write");

   property p_on_clear_keeps;
      @(posedge ref_clk) disable iff (!reset_n)
      (wr_hi && !wr_lo && !writedata[`REF_ON_BIT]) |=> $stable(low_q) && !ladder_enable;
   endproperty
   a_on_clear_keeps: assert property (p_on_clear_keeps)
      else $error("disable changed other fields");

   property p_oe_write;
      @(posedge ref_clk) disable iff (!reset_n)
      wr_lo |=> ref_pin_output_enable == $past(writedata[`REF_OE_BIT]);
   endproperty
   a_oe_write: assert property (p_oe_write)
      else $error("pin enable wrong after write");

   property p_range_src_write;
      @(posedge ref_clk) disable iff (!reset_n)
      wr_lo |=> ref_range_select == $past(writedata[`REF_RANGE_BIT])
         && ref_source_select == $past(writedata[`REF_SRC_BIT]);
   endproperty
   a_range_src_write: assert property (p_range_src_write)
      else $error("range or source wrong after write");

   property p_unimpl_zero;
      @(posedge ref_clk) disable iff (!reset_n)
      !waitrequest && $past(read) |-> (readdata & ~`REF_IMPL_MASK) == 32'h0;
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero)
      else $error("unimplemented bits read nonzero");

   property p_static_outputs;
      @(posedge ref_clk) disable iff (!reset_n)
      !wr_lo |=> $stable(ref_level_code) && $stable(ref_pin_output_enable);
   endproperty
   a_static_outputs: assert property (p_static_outputs)
      else $error("control output changed without write");

   property p_static_mode;
      @(posedge ref_clk) disable iff (!reset_n)
      !wr_lo |=> $stable(ref_range_select) && $stable(ref_source_select);
   endproperty
   a_static_mode: assert property (p_static_mode)
      else $error("range or source changed without write");

   property p_static_enable;
      @(posedge ref_clk) disable iff (!reset_n)
      !wr_hi |=> $stable(ladder_enable);
   endproperty
   a_static_enable: assert property (p_static_enable)
      else $error("enable changed without write");

   property p_level_write;
      @(posedge ref_clk) disable iff (!reset_n)
      wr_lo |=> ref_level_code == $past(writedata[`REF_LEVEL_MSB:`REF_LEVEL_LSB]);
   endproperty
   a_level_write: assert property (p_level_write)
      else $error("level code wrong after write");

   // Unmapped words answer like the register, but with zero data
   property p_unmapped_read;
      @(posedge ref_clk) disable iff (!reset_n)
      read && !hit && ack_nxt |=> readdata == `REF_UNMAPPED_DATA;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read returned nonzero");

   // With no request pending the slave must keep the master waiting
   property p_idle_wait;
      @(posedge ref_clk) disable iff (!reset_n)
      !read && !write |=> waitrequest;
   endproperty
   a_idle_wait: assert property (p_idle_wait)
      else $error("waitrequest low with no request");

   property p_reset_clear;
      @(posedge ref_clk) !reset_n |=> !ladder_enable && low_q == 7'h00 && waitrequest;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("fields not cleared by reset");

   property p_answer_time;
      @(posedge ref_clk) disable iff (!reset_n)
      ((read || write) && waitrequest) |=> !waitrequest;
   endproperty
   a_answer_time: assert property (p_answer_time)
      else $error("request not answered in one cycle");

   c_enable_on: cover property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(ladder_enable));
   c_low_range: cover property (@(posedge ref_clk) disable iff (!reset_n)
      ladder_enable && ref_range_select == RANGE_LOW && ref_pin_output_enable);
   c_ext_source: cover property (@(posedge ref_clk) disable iff (!reset_n)
      ref_source_select && ref_level_code == 4'hf);
   c_bad_addr: cover property (@(posedge ref_clk) disable iff (!reset_n)
      read && !hit && !waitrequest);
   c_disable_keeps: cover property (@(posedge ref_clk) disable iff (!reset_n)
      $fell(ladder_enable) && ref_level_code != 4'h0);
endmodule // reference_ladder_control
